// >>> testbench/swm_remote.sv
/*
   Model of the remote serial device that shares the three pin lines with the wire mode block.
   Assumes the block drives out, oe and pullup per pin and that lines 1 and 2 carry bus pull-ups.
*/
`timescale 1ns/100ps
module swm_remote (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] pin_pullup,
   output logic [2:0] pin_line
);
   logic [2:0] rem_low = 3'h0;
   logic last0 = 1'b0;
   // Clock and data lines are wired-AND: any party pulling low wins over the bus pull-up.
   assign pin_line[2:1] = ~((pin_oe[2:1] & ~pin_out[2:1]) | rem_low[2:1]);
   // A floating output line shows the inverse of its last level, so no lucky default can pass.
   assign pin_line[0] = pin_oe[0] ? pin_out[0] : (pin_pullup[0] ? 1'b1 : ~last0);
   always @(pin_out[0] or pin_oe[0])
   begin
      if (pin_oe[0])
         last0 = pin_out[0];
   end
   // Each call holds the new line state for half of a 125 ns link clock period.
   task automatic drive(input logic [2:0] low);
      rem_low = low;
      #62.5;
   endtask
endmodule // swm_remote

// >>> testbench/tb.sv
/*
   Self-checking bench of the wire mode block: register tests over AXI4-Lite and a remote pin model.
   Assumes the design files and the swm_remote model are compiled before it.
*/
`timescale 1ns/100ps
`include "swm_regs.svh"
module tb;
   localparam logic [7:0] CTL = `SWM_OFS_CONTROL;
   localparam logic [7:0] STA = `SWM_OFS_STATUS;
   localparam logic [7:0] DAT = `SWM_OFS_DATA;
   localparam logic [7:0] LAT = `SWM_OFS_LATCH;
   localparam logic [7:0] DIR = `SWM_OFS_DIR;
   localparam logic [7:0] GIE = `SWM_OFS_GLOBAL;
   localparam logic [1:0] OK = `SWM_RESP_OKAY;
   localparam logic [1:0] ERR = `SWM_RESP_SLVERR;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] pin_line, pin_out, pin_oe, pin_pullup;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;

   always #4 clock = ~clock;

   swm_wire_ctrl #(.ADDR_W(8)) i_dut (.clock(clock), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_line),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .irq(irq));

   swm_remote i_rem (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .pin_line(pin_line));

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A hung handshake is cut short here and reported as a mismatch.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         $display("[FAIL] run_length expected below 20000 seen 20000");
         summarize();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_busy;
      logic w_busy;
      aw_busy = 1'b1;
      w_busy = 1'b1;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (aw_busy && awready)
         begin
            aw_busy = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_busy && wready)
         begin
            w_busy = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (!(bvalid === 1'b1 && !aw_busy && !w_busy));
      // The response ready stays up between writes, so back-to-back calls never toggle it twice.
      chk($sformatf("bresp %h", a), {6'h00, bresp}, {6'h00, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      chk($sformatf("rdata %h", a), rdata[7:0], exp);
      chk($sformatf("rresp %h", a), {6'h00, rresp}, {6'h00, er});
   endtask

   // Output enable, driven level where enabled, and pull-up, compared under a pin mask.
   task automatic pins(input logic [2:0] m, input logic [2:0] oe, input logic [2:0] out,
      input logic [2:0] pu);
      chk("pin_oe", {5'h00, pin_oe & m}, {5'h00, oe & m});
      chk("pin_out", {5'h00, pin_out & oe & m}, {5'h00, out & oe & m});
      chk("pin_pullup", {5'h00, pin_pullup & m}, {5'h00, pu & m});
   endtask

   initial
   begin
      wt(8);
      srst <= 1'b0;
      wt(3);
      rd(CTL, `SWM_CTRL_RESET, OK);
      rd(STA, 8'h00, OK);
      rd(8'h18, 8'h00, ERR);
      wr(8'h18, 8'hFF, ERR);
      // A write with byte lane 0 off is answered but must leave the register alone.
      wstrb <= 4'h0;
      wr(LAT, 8'h07, OK);
      wstrb <= 4'hF;
      rd(LAT, 8'h00, OK);
      $display("test reset_and_map done");
      wr(LAT, 8'h05, OK);
      wr(DIR, 8'h03, OK);
      wt(4);
      pins(3'h7, 3'h3, 3'h1, 3'h4);
      repeat (3)
      begin
         i_rem.drive(3'h4);
         i_rem.drive(3'h0);
      end
      wt(8);
      rd(STA, 8'h86, OK);
      wr(STA, 8'hC0, OK);
      rd(STA, 8'h00, OK);
      $display("test mode_off done");
      wr(CTL, 8'h10, OK);
      wr(LAT, 8'h00, OK);
      wr(DIR, 8'h01, OK);
      wr(DAT, 8'h80, OK);
      wt(4);
      pins(3'h1, 3'h1, 3'h1, 3'h0);
      wr(DAT, 8'h00, OK);
      wt(4);
      pins(3'h1, 3'h1, 3'h0, 3'h0);
      wr(DIR, 8'h00, OK);
      wr(LAT, 8'h07, OK);
      wt(4);
      pins(3'h7, 3'h0, 3'h0, 3'h7);
      wr(CTL, 8'h11, OK);
      rd(LAT, 8'h03, OK);
      rd(CTL, 8'h10, OK);
      $display("test mode_three_wire done");
      wr(CTL, 8'h20, OK);
      wr(LAT, 8'h07, OK);
      wr(DIR, 8'h06, OK);
      wr(DAT, 8'hFF, OK);
      wt(4);
      pins(3'h6, 3'h0, 3'h0, 3'h0);
      wr(DAT, 8'h7F, OK);
      wt(4);
      pins(3'h6, 3'h2, 3'h0, 3'h0);
      wr(DAT, 8'hFF, OK);
      wr(LAT, 8'h05, OK);
      wt(4);
      pins(3'h6, 3'h2, 3'h0, 3'h0);
      wr(LAT, 8'h07, OK);
      wr(DIR, 8'h04, OK);
      wr(DAT, 8'h00, OK);
      wt(4);
      pins(3'h6, 3'h0, 3'h0, 3'h0);
      wr(STA, 8'hC0, OK);
      wr(GIE, 8'h01, OK);
      i_rem.drive(3'h2);
      wt(8);
      rd(STA, 8'h80, OK);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(CTL, 8'hA0, OK);
      wt(2);
      chk("irq", {7'h00, irq}, 8'h01);
      wr(GIE, 8'h00, OK);
      wt(2);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(GIE, 8'h01, OK);
      i_rem.drive(3'h6);
      i_rem.drive(3'h0);
      wt(8);
      chk("scl_hold_oe", {7'h00, pin_oe[2]}, 8'h01);
      chk("scl_line", {7'h00, pin_line[2]}, 8'h00);
      wr(STA, 8'h80, OK);
      wt(6);
      chk("scl_hold_oe", {7'h00, pin_oe[2]}, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      $display("test mode_two_wire done");
      wr(CTL, 8'h70, OK);
      wr(STA, 8'h0E, OK);
      i_rem.drive(3'h4);
      i_rem.drive(3'h0);
      wt(8);
      chk("ovf_hold_oe", {7'h00, pin_oe[2]}, 8'h01);
      rd(STA, 8'h41, OK);
      chk("irq", {7'h00, irq}, 8'h01);
      wr(STA, 8'h40, OK);
      wt(6);
      chk("ovf_hold_oe", {7'h00, pin_oe[2]}, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      $display("test mode_two_wire_hold done");
      summarize();
   end
endmodule // tb

// >>> verilog/swm_pkg.sv
/*
   Types shared by the serial wire mode block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package swm_pkg;
   typedef enum logic [1:0] {
      SWM_OFF = 2'h0,
      SWM_THREE = 2'h1,
      SWM_TWO = 2'h2,
      SWM_TWO_HOLD = 2'h3
   } swm_mode_type;
   typedef enum logic [2:0] {
      SWM_R_CONTROL = 3'h0,
      SWM_R_STATUS = 3'h1,
      SWM_R_DATA = 3'h2,
      SWM_R_LATCH = 3'h3,
      SWM_R_DIR = 3'h4,
      SWM_R_GLOBAL = 3'h5,
      SWM_R_NONE = 3'h7
   } swm_reg_type;
endpackage

// >>> verilog/swm_regs.svh
/*
   Register offsets, field positions, reset values and bus answers of the serial wire mode block.
   Assumes inclusion by bare name from files on the verilog/ search path.
*/
// What this block does
// [RQ1] A set start interrupt enable with global enable raises the start interrupt, even for a flag already pending.
// [RQ2] A set overflow interrupt enable with global enable raises the overflow interrupt, even for a flag already pending.
// [RQ3] The wire mode changes only the outputs, so clock and data inputs always feed the counter and shift register.
// [RQ4] Wire mode 00 disables serial outputs, clock hold and start detection, leaving the pins as plain port pins. Clock edges still set the start flag.
// [RQ5] In three-wire mode the shift register top bit replaces the port latch bit on the data output pin, whose direction bit still rules.
// [RQ6] In three-wire mode a data output pin set as input has its pull-up follow the port latch bit.
// [RQ7] In three-wire mode the data input and clock pins keep normal port operation and only feed the serial unit.
// [RQ8] A three-wire master makes clock pulses in software by toggling the clock pin latch bit with the pin set as output.
// [RQ9] In two-wire mode the data and clock lines are open-drain, each driver enabled only by its direction bit.
// [RQ10] In two-wire mode an enabled data driver pulls low when the shift register top bit or the latch bit is zero.
// [RQ11] In two-wire mode an enabled clock driver pulls low when its latch bit is zero or the start detector holds it.
// [RQ12] In two-wire mode a detected start condition holds the clock low until software clears the start flag.
// [RQ13] In two-wire modes the pin inputs are unaffected and the pull-ups on data and clock pins are forced off.
// [RQ14] Wire mode 11 also holds the clock low from a counter overflow until software clears the overflow flag.
// [RQ15] The start flag clears only when software writes a one to it, and that releases the start hold.
// [RQ16] The overflow flag sets when the four-bit counter wraps from fifteen to zero and clears only on a written one.
// [RQ17] Each interrupt request is the AND of its flag, its enable and the global enable, evaluated every cycle.
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
`define SWM_OFS_CONTROL 8'h00
`define SWM_OFS_STATUS 8'h04
`define SWM_OFS_DATA 8'h08
`define SWM_OFS_LATCH 8'h0C
`define SWM_OFS_DIR 8'h10
`define SWM_OFS_GLOBAL 8'h14
`define SWM_BIT_START 7
`define SWM_BIT_OVF 6
`define SWM_BIT_MODE_HI 5
`define SWM_BIT_MODE_LO 4
`define SWM_BIT_TOGGLE 0
`define SWM_PIN_DOUT 0
`define SWM_PIN_SDA 1
`define SWM_PIN_SCL 2
`define SWM_CTRL_RESET 8'h00
`define SWM_CNT_MAX 4'hF
`define SWM_RESP_OKAY 2'h0
`define SWM_RESP_SLVERR 2'h2
`endif

// >>> verilog/swm_wire_ctrl.sv
/*
   Wire mode control, start and overflow flags, interrupt gating and pin drivers of a serial shift
   unit, with an AXI4-Lite register slave.
   Assumes pins arrive asynchronously, and that the pad logic resolves each pin from out and oe.
*/
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "swm_regs.svh"
module swm_wire_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic [2:0] pin_pullup,
   output logic irq
);

   // Pin 0 is the data output, pin 1 the data input (two-wire data), pin 2 the clock.
   function automatic swm_pkg::swm_reg_type reg_decode(input logic [ADDR_W-1:0] addr);
      if (addr == `SWM_OFS_CONTROL)
         reg_decode = swm_pkg::SWM_R_CONTROL;
      else if (addr == `SWM_OFS_STATUS)
         reg_decode = swm_pkg::SWM_R_STATUS;
      else if (addr == `SWM_OFS_DATA)
         reg_decode = swm_pkg::SWM_R_DATA;
      else if (addr == `SWM_OFS_LATCH)
         reg_decode = swm_pkg::SWM_R_LATCH;
      else if (addr == `SWM_OFS_DIR)
         reg_decode = swm_pkg::SWM_R_DIR;
      else if (addr == `SWM_OFS_GLOBAL)
         reg_decode = swm_pkg::SWM_R_GLOBAL;
      else
         reg_decode = swm_pkg::SWM_R_NONE;
   endfunction

   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wstrb0_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] ctrl_reg;
   logic start_flag_reg;
   logic ovf_flag_reg;
   logic [3:0] count_reg;
   logic [7:0] shift_reg;
   logic [2:0] latch_reg;
   logic [2:0] dir_reg;
   logic gie_reg;
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic [2:0] prev_reg;
   logic start_hold_reg;
   logic ovf_hold_reg;
   logic [2:0] pin_out_reg;
   logic [2:0] pin_oe_reg;
   logic [2:0] pin_pullup_reg;
   logic irq_reg;
   logic [2:0] pin_out_next;
   logic [2:0] pin_oe_next;
   logic [2:0] pin_pullup_next;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic wr_en;
   logic ar_take;
   swm_pkg::swm_reg_type wr_sel;
   swm_pkg::swm_reg_type rd_sel;
   swm_pkg::swm_mode_type mode;
   logic two_wire;
   logic scl_rise;
   logic scl_fall;
   logic scl_edge;
   logic sda_fall;
   logic start_event;
   logic ovf_event;
   logic start_clear;
   logic ovf_clear;

   assign aw_take = awready_reg & s_axi_awvalid;
   assign w_take = wready_reg & s_axi_wvalid;
   assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_sel = reg_decode(awaddr_reg);
   assign wr_en = wr_fire & wstrb0_reg;
   assign ar_take = arready_reg & s_axi_arvalid;
   assign rd_sel = reg_decode(s_axi_araddr);
   assign mode = swm_pkg::swm_mode_type'(ctrl_reg[`SWM_BIT_MODE_HI:`SWM_BIT_MODE_LO]);
   assign two_wire = ctrl_reg[`SWM_BIT_MODE_HI];

   // Address and data are held separately so the master may offer them in either order.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb0_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end
      else
      begin
         if (aw_take)
            awaddr_reg <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_reg <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end
         aw_held_reg <= (aw_held_reg | aw_take) & ~wr_fire;
         w_held_reg <= (w_held_reg | w_take) & ~wr_fire;
         awready_reg <= ~((aw_held_reg | aw_take) & ~wr_fire);
         wready_reg <= ~((w_held_reg | w_take) & ~wr_fire);
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `SWM_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_sel == swm_pkg::SWM_R_NONE) ? `SWM_RESP_SLVERR : `SWM_RESP_OKAY;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= `SWM_RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end
      else if (ar_take)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= (rd_sel == swm_pkg::SWM_R_NONE) ? `SWM_RESP_SLVERR : `SWM_RESP_OKAY;
         case (rd_sel)
            swm_pkg::SWM_R_CONTROL: rdata_reg <= {24'h000000, ctrl_reg};
            swm_pkg::SWM_R_STATUS: rdata_reg <= {24'h000000, start_flag_reg, ovf_flag_reg,
                                                 2'h0, count_reg};
            swm_pkg::SWM_R_DATA: rdata_reg <= {24'h000000, shift_reg};
            swm_pkg::SWM_R_LATCH: rdata_reg <= {29'h00000000, latch_reg};
            swm_pkg::SWM_R_DIR: rdata_reg <= {29'h00000000, dir_reg};
            swm_pkg::SWM_R_GLOBAL: rdata_reg <= {31'h00000000, gie_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
      else if (rvalid_reg & s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
      else if (~rvalid_reg)
         arready_reg <= 1'b1;
   end

   // The strobe bit is never stored, so it always reads as zero.
   always_ff @(posedge clock)
   begin
      if (srst)
         ctrl_reg <= `SWM_CTRL_RESET;
      else if (wr_en && wr_sel == swm_pkg::SWM_R_CONTROL)
         ctrl_reg <= {wdata_reg[7:4], 4'h0};
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         dir_reg <= 3'h0;
         gie_reg <= 1'b0;
      end
      else if (wr_en && wr_sel == swm_pkg::SWM_R_DIR)
         dir_reg <= wdata_reg[2:0];
      else if (wr_en && wr_sel == swm_pkg::SWM_R_GLOBAL)
         gie_reg <= wdata_reg[0];
   end

   // A one in the strobe bit of a control write toggles the clock pin latch for software clocking.
   always_ff @(posedge clock)
   begin
      if (srst)
         latch_reg <= 3'h0;
      else if (wr_en && wr_sel == swm_pkg::SWM_R_LATCH)
         latch_reg <= wdata_reg[2:0];
      else if (wr_en && wr_sel == swm_pkg::SWM_R_CONTROL && wdata_reg[`SWM_BIT_TOGGLE]) // [RQ8]
         latch_reg[`SWM_PIN_SCL] <= ~latch_reg[`SWM_PIN_SCL];
   end

   // Three flops per pin; edges are found only from the second stage onward.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         meta_reg <= 3'h7;
         sync_reg <= 3'h7;
         prev_reg <= 3'h7;
      end
      else
      begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign scl_rise = sync_reg[`SWM_PIN_SCL] & ~prev_reg[`SWM_PIN_SCL];
   assign scl_fall = ~sync_reg[`SWM_PIN_SCL] & prev_reg[`SWM_PIN_SCL];
   assign scl_edge = scl_rise | scl_fall;
   assign sda_fall = ~sync_reg[`SWM_PIN_SDA] & prev_reg[`SWM_PIN_SDA];
   // Outside two-wire modes any clock edge sets the start flag; in them only a start condition.
   assign start_event = two_wire ? (sda_fall & sync_reg[`SWM_PIN_SCL]) : scl_edge;
   assign ovf_event = scl_edge & (count_reg == `SWM_CNT_MAX);
   assign start_clear = wr_en && wr_sel == swm_pkg::SWM_R_STATUS && wdata_reg[`SWM_BIT_START];
   assign ovf_clear = wr_en && wr_sel == swm_pkg::SWM_R_STATUS && wdata_reg[`SWM_BIT_OVF];

   // Inputs feed counter and shift register in every mode, outputs disabled or not.
   always_ff @(posedge clock)
   begin
      if (srst)
         count_reg <= 4'h0;
      else if (wr_en && wr_sel == swm_pkg::SWM_R_STATUS)
         count_reg <= wdata_reg[3:0];
      else if (scl_edge) // [RQ3]
         count_reg <= count_reg + 4'h1;
   end

   // A write in the same cycle as a shift keeps the written value.
   always_ff @(posedge clock)
   begin
      if (srst)
         shift_reg <= 8'h00;
      else if (wr_en && wr_sel == swm_pkg::SWM_R_DATA)
         shift_reg <= wdata_reg[7:0];
      else if (scl_rise) // [RQ3]
         shift_reg <= {shift_reg[6:0], sync_reg[`SWM_PIN_SDA]};
   end

   // Set wins over a clear that lands in the same cycle, so no event is lost.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         start_flag_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
      end
      else
      begin
         start_flag_reg <= start_event | (start_flag_reg & ~start_clear); // [RQ15]
         ovf_flag_reg <= ovf_event | (ovf_flag_reg & ~ovf_clear); // [RQ16]
      end
   end

   // The start hold begins at the first clock fall after a start and lasts until the flag clears.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         start_hold_reg <= 1'b0;
         ovf_hold_reg <= 1'b0;
      end
      else
      begin
         if (~two_wire | ~start_flag_reg) // [RQ12] [RQ15]
            start_hold_reg <= 1'b0;
         else if (scl_fall)
            start_hold_reg <= 1'b1;
         if (mode != swm_pkg::SWM_TWO_HOLD | (~ovf_flag_reg & ~ovf_event)) // [RQ14]
            ovf_hold_reg <= 1'b0;
         else if (ovf_event)
            ovf_hold_reg <= 1'b1;
      end
   end

   always_comb
   begin
      pin_out_next = latch_reg;
      pin_oe_next = dir_reg;
      pin_pullup_next = ~dir_reg & latch_reg;
      case (mode)
         swm_pkg::SWM_OFF:
         begin
            pin_out_next = latch_reg; // [RQ4]
         end
         swm_pkg::SWM_THREE:
         begin
            pin_out_next[`SWM_PIN_DOUT] = shift_reg[7]; // [RQ5] [RQ6] [RQ7]
         end
         default:
         begin
            pin_out_next[`SWM_PIN_SDA] = 1'b0; // [RQ9]
            pin_out_next[`SWM_PIN_SCL] = 1'b0;
            pin_oe_next[`SWM_PIN_SDA] = dir_reg[`SWM_PIN_SDA]
               & ~(shift_reg[7] & latch_reg[`SWM_PIN_SDA]); // [RQ10]
            pin_oe_next[`SWM_PIN_SCL] = dir_reg[`SWM_PIN_SCL]
               & (~latch_reg[`SWM_PIN_SCL] | start_hold_reg | ovf_hold_reg); // [RQ11] [RQ14]
            pin_pullup_next[`SWM_PIN_SDA] = 1'b0; // [RQ13]
            pin_pullup_next[`SWM_PIN_SCL] = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pin_out_reg <= 3'h0;
         pin_oe_reg <= 3'h0;
         pin_pullup_reg <= 3'h0;
      end
      else
      begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         pin_pullup_reg <= pin_pullup_next;
      end
   end

   // Enables mask flags of the same bit positions; a pending flag fires as soon as both enable.
   always_ff @(posedge clock)
   begin
      if (srst)
         irq_reg <= 1'b0;
      else
         irq_reg <= gie_reg & ((start_flag_reg & ctrl_reg[`SWM_BIT_START]) // [RQ1] [RQ17]
            | (ovf_flag_reg & ctrl_reg[`SWM_BIT_OVF])); // [RQ2]
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign pin_pullup = pin_pullup_reg;
   assign irq = irq_reg;

   start_irq_a: assert property (@(posedge clock) disable iff (srst) // [RQ1]
      (start_flag_reg && ctrl_reg[7] && gie_reg) |=> irq)
      else $error("Pending start flag did not raise the interrupt.");

   ovf_irq_a: assert property (@(posedge clock) disable iff (srst) // [RQ2]
      (ovf_flag_reg && ctrl_reg[6] && gie_reg) |=> irq)
      else $error("Pending overflow flag did not raise the interrupt.");

   irq_gate_a: assert property (@(posedge clock) disable iff (srst) // [RQ17]
      irq |-> $past(gie_reg) && (($past(start_flag_reg) && $past(ctrl_reg[7]))
         || ($past(ovf_flag_reg) && $past(ctrl_reg[6]))))
      else $error("Interrupt raised without an enabled flag.");

   input_count_a: assert property (@(posedge clock) disable iff (srst) // [RQ3]
      (scl_edge && !(wr_en && wr_sel == swm_pkg::SWM_R_STATUS))
         |=> count_reg == $past(count_reg) + 4'h1)
      else $error("Clock edge did not advance the counter.");

   off_mode_a: assert property (@(posedge clock) disable iff (srst) // [RQ4]
      (mode == swm_pkg::SWM_OFF) |=> pin_out == $past(latch_reg) && pin_oe == $past(dir_reg))
      else $error("Port pins not in plain port behaviour in mode 00.");

   three_dout_a: assert property (@(posedge clock) disable iff (srst) // [RQ5]
      (mode == swm_pkg::SWM_THREE) |=> pin_out[0] == $past(shift_reg[7])
         && pin_oe[0] == $past(dir_reg[0]))
      else $error("Data output pin not fed by the shift register.");

   sda_drive_a: assert property (@(posedge clock) disable iff (srst) // [RQ10]
      (two_wire && dir_reg[1] && !shift_reg[7]) |=> pin_oe[1] && !pin_out[1])
      else $error("Two-wire data line not pulled low.");

   pullup_off_a: assert property (@(posedge clock) disable iff (srst) // [RQ13]
      two_wire |=> pin_pullup[2:1] == 2'h0)
      else $error("Two-wire pull-ups not forced off.");

   start_hold_a: assert property (@(posedge clock) disable iff (srst) // [RQ12]
      (start_hold_reg && dir_reg[2]) |=> pin_oe[2] || !$past(start_flag_reg))
      else $error("Start hold released the clock line early.");

   ovf_set_a: assert property (@(posedge clock) disable iff (srst) // [RQ16]
      (scl_edge && count_reg == 4'hF) |=> ovf_flag_reg)
      else $error("Counter wrap did not set the overflow flag.");

   ovf_hold_a: assert property (@(posedge clock) disable iff (srst) // [RQ14]
      (mode == swm_pkg::SWM_TWO_HOLD && ovf_event) |=> ovf_hold_reg [*2] or !ovf_flag_reg)
      else $error("Overflow did not hold the clock line.");

endmodule // swm_wire_ctrl
